// *** design/csrb_register_bank.sv ***
/*
 * Charger command register bank behind a serial bus (word read/write)
 * slave, with watchdog, discharge cycle and adapter-present deglitch.
 * Assumes pins and comparator results arrive asynchronously; the
 * analogue side consumes the setting outputs.
 */
// Overview of operation
// - six commands by word write or read; command byte selects.
// - identity registers FE and FF read-only, fixed 16-bit codes.
// - option register 12 read/write, resets to 7904.
// - charge current 14 read/write, 7-bit, resets to zero.
// - charge voltage 15 read/write, 11-bit, resets to zero.
// - input current 3F read/write, 6-bit, resets to 1000.
// - option bit 15 picks adapter-present rise deglitch, 150ms or 1.3s.
// - long deglitch only after adapter switch turned on then off.
// - watchdog suspends charging without current or voltage write in time.
// - suspended charging resumes on next current or voltage write.
// - option bits 12:11 select battery depletion threshold fraction.
// - depletion in discharge: battery switch off, adapter switch on.
// - writing 1 to option bit 6 starts discharge cycle; reset value 0.
// - bit 6 self-clears on completion; writing 0 aborts.
// - option bit 9 enables frequency shift, bit 10 picks its direction.
// - option bits 8:7 select high-side short threshold.
// - option bit 5 routes current monitor output source.
// - option bits 2:1 set input overcurrent threshold or disable it.
// - bus answers only with supply above lockout and adapter detect valid.
// - slave only, address 09 (7-bit); never starts a transfer.
// - out-of-range charge current write clears register, stops charging.
module csrb_register_bank #(
   parameter logic [31:0] DGL_SHORT_CYC = csrb_pkg::DGL_SHORT_CYC,
   parameter logic [31:0] DGL_LONG_CYC = csrb_pkg::DGL_LONG_CYC,
   parameter logic [31:0] WD_44_CYC = csrb_pkg::WD_44_CYC,
   parameter logic [31:0] WD_88_CYC = csrb_pkg::WD_88_CYC,
   parameter logic [31:0] WD_175_CYC = csrb_pkg::WD_175_CYC,
   // identity values are arbitrary
   parameter logic [15:0] MAKER_ID_VAL = 16'h00A5,
   parameter logic [15:0] PART_ID_VAL = 16'h005A
) (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   // serial bus pins
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_out,
   output logic o_sda_oe_n,
   // analogue status
   input wire logic i_supply_lockout,
   input wire logic i_adapter_detect_ok,
   input wire logic i_adapter_present_raw,
   input wire logic i_battery_depleted,
   // power path and charge control
   output logic o_adapter_present_flag,
   output logic o_adapter_path_switch,
   output logic o_battery_path_switch,
   output logic o_charge_enable,
   // option fields
   output logic [1:0] o_depletion_sel,
   output logic o_freq_adj_en,
   output logic o_freq_adj_up,
   output logic [1:0] o_high_side_short_threshold,
   output logic o_current_monitor_output_sel,
   output logic [1:0] o_input_overcurrent_limit,
   output logic o_charge_inhibit,
   // settings
   output logic [6:0] o_charge_current,
   output logic [10:0] o_charge_voltage,
   output logic [5:0] o_input_current
);

   logic [5:0] sync_q;
   logic scl_s, sda_s, lock_s, adet_s, ap_s, depl_s;
   logic scl_q, sda_q;
   logic scl_rise, scl_fall, start_c, stop_c, comm_en;
   csrb_pkg::csrb_state_e st;
   logic [3:0] cnt;
   logic [7:0] shreg;
   logic [7:0] cmd;
   logic [7:0] lo_byte;
   logic mack;
   logic tx;
   logic cmd_ok;
   logic [15:0] rd_word;
   logic wr_stb;
   logic [7:0] wr_cmd;
   logic [15:0] wr_data;
   logic [15:0] opt;
   logic [31:0] wd_cnt;
   logic [31:0] wd_lim;
   logic charge_run;
   logic [31:0] dg_cnt;
   logic [31:0] dg_lim;
   logic long_armed;
   logic ac_sw_q;
   logic wr_cc, wr_cv, wr_ic, wr_opt;
   logic [6:0] wr_cc_code;
   logic [10:0] wr_cv_code;

   csrb_sync #(
      .W(6)
   ) u_sync (
      .i_core_clk(i_core_clk),
      .i_reset_n(i_reset_n),
      .i_async({i_scl, i_sda, i_supply_lockout, i_adapter_detect_ok,
                i_adapter_present_raw, i_battery_depleted}),
      .o_sync(sync_q)
   );

   assign {scl_s, sda_s, lock_s, adet_s, ap_s, depl_s} = sync_q;

   // bus edge and condition detection
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_s;
         sda_q <= sda_s;
      end
   end

   assign scl_rise = scl_s & ~scl_q;
   assign scl_fall = ~scl_s & scl_q;
   assign start_c = scl_s & scl_q & sda_q & ~sda_s;
   assign stop_c = scl_s & scl_q & ~sda_q & sda_s;
   assign comm_en = ~lock_s & adet_s;
   assign tx = (st == csrb_pkg::ST_RLO) || (st == csrb_pkg::ST_RHI);

   // data is acknowledged or returned only for the six commands; any command byte is acknowledged
   always_comb begin
      cmd_ok = 1'b1;
      rd_word = 16'h0000;
      case (cmd)
         csrb_pkg::CMD_OPTION: rd_word = opt;
         csrb_pkg::CMD_CHG_CURRENT: rd_word = 16'(o_charge_current) << csrb_pkg::CC_LSB;
         csrb_pkg::CMD_CHG_VOLTAGE: rd_word = 16'(o_charge_voltage) << csrb_pkg::CV_LSB;
         csrb_pkg::CMD_IN_CURRENT: rd_word = 16'(o_input_current) << csrb_pkg::IC_LSB;
         csrb_pkg::CMD_MAKER_ID: rd_word = MAKER_ID_VAL;
         csrb_pkg::CMD_PART_ID: rd_word = PART_ID_VAL;
         default: cmd_ok = 1'b0;
      endcase
   end

   // byte engine; slave only, never drives scl
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st <= csrb_pkg::ST_IDLE;
         cnt <= 4'h0;
         shreg <= 8'h00;
         cmd <= 8'h00;
         lo_byte <= 8'h00;
         mack <= 1'b0;
         o_sda_oe_n <= 1'b1;
         wr_stb <= 1'b0;
         wr_cmd <= 8'h00;
         wr_data <= 16'h0000;
      end else begin
         wr_stb <= 1'b0;
         if (!comm_en || stop_c) begin
            st <= csrb_pkg::ST_IDLE;
            cnt <= 4'h0;
            o_sda_oe_n <= 1'b1;
         end else if (start_c) begin
            st <= csrb_pkg::ST_ADDR;
            cnt <= 4'h0;
            o_sda_oe_n <= 1'b1;
         end else if (scl_rise) begin
            if (cnt < 4'h8) begin
               cnt <= cnt + 4'h1;
               if (!tx) begin
                  shreg <= {shreg[6:0], sda_s};
               end
            end else if (cnt == 4'h9) begin
               mack <= ~sda_s;
            end
         end else if (scl_fall && (st != csrb_pkg::ST_IDLE || cnt == 4'h9)) begin
            if (cnt == 4'h8) begin
               cnt <= 4'h9;
               o_sda_oe_n <= 1'b1;
               case (st)
                  csrb_pkg::ST_ADDR: begin
                     if (shreg[7:1] == csrb_pkg::SLAVE_ADDR) begin
                        o_sda_oe_n <= 1'b0;
                        st <= shreg[0] ? csrb_pkg::ST_RSTART : csrb_pkg::ST_CMD;
                     end else begin
                        st <= csrb_pkg::ST_IDLE;
                     end
                  end
                  csrb_pkg::ST_CMD: begin
                     cmd <= shreg;
                     o_sda_oe_n <= 1'b0;
                     st <= csrb_pkg::ST_WLO;
                  end
                  csrb_pkg::ST_WLO: begin
                     if (cmd_ok) begin
                        lo_byte <= shreg;
                        o_sda_oe_n <= 1'b0;
                        st <= csrb_pkg::ST_WHI;
                     end else begin
                        st <= csrb_pkg::ST_IDLE;
                     end
                  end
                  csrb_pkg::ST_WHI: begin
                     o_sda_oe_n <= 1'b0;
                     wr_stb <= 1'b1;
                     wr_cmd <= cmd;
                     wr_data <= {shreg, lo_byte};
                     st <= csrb_pkg::ST_IDLE;
                  end
                  default: ;
               endcase
            end else if (cnt == 4'h9) begin
               cnt <= 4'h0;
               o_sda_oe_n <= 1'b1;
               case (st)
                  csrb_pkg::ST_RSTART: begin
                     if (cmd_ok) begin
                        shreg <= {rd_word[6:0], 1'b0};
                        o_sda_oe_n <= rd_word[7];
                        st <= csrb_pkg::ST_RLO;
                     end else begin
                        st <= csrb_pkg::ST_IDLE;
                     end
                  end
                  csrb_pkg::ST_RLO: begin
                     if (mack) begin
                        shreg <= {rd_word[14:8], 1'b0};
                        o_sda_oe_n <= rd_word[15];
                        st <= csrb_pkg::ST_RHI;
                     end else begin
                        st <= csrb_pkg::ST_IDLE;
                     end
                  end
                  csrb_pkg::ST_RHI: st <= csrb_pkg::ST_IDLE;
                  default: ;
               endcase
            end else if (tx && cnt != 4'h0) begin
               o_sda_oe_n <= shreg[7];
               shreg <= {shreg[6:0], 1'b0};
            end
         end
      end
   end

   // the line is only ever pulled low
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_sda_out <= 1'b0;
      end else begin
         o_sda_out <= 1'b0;
      end
   end

   // write decode; identity commands fall through
   assign wr_opt = wr_stb && wr_cmd == csrb_pkg::CMD_OPTION;
   assign wr_cc = wr_stb && wr_cmd == csrb_pkg::CMD_CHG_CURRENT;
   assign wr_cv = wr_stb && wr_cmd == csrb_pkg::CMD_CHG_VOLTAGE;
   assign wr_ic = wr_stb && wr_cmd == csrb_pkg::CMD_IN_CURRENT;
   assign wr_cc_code = wr_data[csrb_pkg::CC_LSB +: csrb_pkg::CC_W];
   assign wr_cv_code = wr_data[csrb_pkg::CV_LSB +: csrb_pkg::CV_W];

   // option register; hardware clears the discharge bit on depletion
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         opt <= csrb_pkg::OPT_RST;
      end else if (wr_opt) begin
         opt <= wr_data & csrb_pkg::OPT_WMASK;
      end else if (opt[csrb_pkg::OPT_LEARN] && depl_s) begin
         opt[csrb_pkg::OPT_LEARN] <= 1'b0;
      end
   end

   assign o_depletion_sel = opt[csrb_pkg::OPT_DEPL_LSB +: 2];
   assign o_freq_adj_en = opt[csrb_pkg::OPT_FREQ_EN];
   assign o_freq_adj_up = opt[csrb_pkg::OPT_FREQ_UP];
   assign o_high_side_short_threshold = opt[csrb_pkg::OPT_SHORT_LSB +: 2];
   assign o_current_monitor_output_sel = opt[csrb_pkg::OPT_MON_SEL];
   assign o_input_overcurrent_limit = opt[csrb_pkg::OPT_OVC_LSB +: 2];
   assign o_charge_inhibit = opt[csrb_pkg::OPT_INHIBIT];

   // charge current setting
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_charge_current <= csrb_pkg::CC_RST[csrb_pkg::CC_LSB +: csrb_pkg::CC_W];
      end else if (wr_cc) begin
         if (wr_cc_code < csrb_pkg::CC_MIN_CODE) begin
            o_charge_current <= 7'h00;
         end else begin
            o_charge_current <= wr_cc_code;
         end
      end
   end

   // charge voltage setting
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_charge_voltage <= csrb_pkg::CV_RST[csrb_pkg::CV_LSB +: csrb_pkg::CV_W];
      end else if (wr_cv) begin
         if (wr_cv_code < csrb_pkg::CV_MIN_CODE || wr_cv_code > csrb_pkg::CV_MAX_CODE) begin
            o_charge_voltage <= 11'h000;
         end else begin
            o_charge_voltage <= wr_cv_code;
         end
      end
   end

   // input current setting
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_input_current <= csrb_pkg::IC_RST[csrb_pkg::IC_LSB +: csrb_pkg::IC_W];
      end else if (wr_ic) begin
         o_input_current <= wr_data[csrb_pkg::IC_LSB +: csrb_pkg::IC_W];
      end
   end

   // watchdog period select
   always_comb begin
      case (opt[csrb_pkg::OPT_WD_LSB +: 2])
         csrb_pkg::WD_44: wd_lim = WD_44_CYC;
         csrb_pkg::WD_88: wd_lim = WD_88_CYC;
         default: wd_lim = WD_175_CYC;
      endcase
   end

   // watchdog: restarted by any current or voltage write
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         wd_cnt <= 32'h0000_0000;
         charge_run <= 1'b1;
      end else if (wr_cc || wr_cv) begin
         wd_cnt <= 32'h0000_0000;
         charge_run <= 1'b1;
      end else if (opt[csrb_pkg::OPT_WD_LSB +: 2] == csrb_pkg::WD_OFF) begin
         wd_cnt <= 32'h0000_0000;
      end else if (charge_run) begin
         if (wd_cnt >= wd_lim - 32'h1) begin
            charge_run <= 1'b0;
         end else begin
            wd_cnt <= wd_cnt + 32'h1;
         end
      end
   end

   // charge permitted only with both settings live
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_charge_enable <= 1'b0;
      end else begin
         o_charge_enable <= charge_run && o_charge_current != 7'h00
                            && o_charge_voltage != 11'h000 && !opt[csrb_pkg::OPT_INHIBIT];
      end
   end

   // arm long deglitch on first switch-off
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ac_sw_q <= 1'b0;
         long_armed <= 1'b0;
      end else begin
         ac_sw_q <= o_adapter_path_switch;
         if (ac_sw_q && !o_adapter_path_switch) begin
            long_armed <= 1'b1;
         end
      end
   end

   assign dg_lim = (opt[csrb_pkg::OPT_DGL_LONG] && long_armed) ? DGL_LONG_CYC : DGL_SHORT_CYC;

   // deglitch rises only; falls pass at once
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         dg_cnt <= 32'h0000_0000;
         o_adapter_present_flag <= 1'b0;
      end else if (!ap_s) begin
         dg_cnt <= 32'h0000_0000;
         o_adapter_present_flag <= 1'b0;
      end else if (!o_adapter_present_flag) begin
         if (dg_cnt >= dg_lim - 32'h1) begin
            o_adapter_present_flag <= 1'b1;
         end else begin
            dg_cnt <= dg_cnt + 32'h1;
         end
      end
   end

   // power path selection
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_adapter_path_switch <= 1'b0;
         o_battery_path_switch <= 1'b1;
      end else begin
         o_adapter_path_switch <= o_adapter_present_flag && !opt[csrb_pkg::OPT_LEARN];
         o_battery_path_switch <= opt[csrb_pkg::OPT_LEARN] || !o_adapter_present_flag;
      end
   end

endmodule : csrb_register_bank

// *** design/csrb_pkg.sv ***
/*
 * Shared constants of the charger register bank: codes, layouts, resets,
 * timing and states. Assumes a single 10 MHz core clock.
 */
package csrb_pkg;

   // 7-bit slave address
   localparam logic [6:0] SLAVE_ADDR = 7'h09;

   // command codes
   localparam logic [7:0] CMD_OPTION = 8'h12;
   localparam logic [7:0] CMD_CHG_CURRENT = 8'h14;
   localparam logic [7:0] CMD_CHG_VOLTAGE = 8'h15;
   localparam logic [7:0] CMD_IN_CURRENT = 8'h3F;
   localparam logic [7:0] CMD_MAKER_ID = 8'hFE;
   localparam logic [7:0] CMD_PART_ID = 8'hFF;

   // option register layout
   localparam logic [15:0] OPT_RST = 16'h7904;
   localparam logic [15:0] OPT_WMASK = 16'hFFE7;
   localparam int OPT_DGL_LONG = 15;
   localparam int OPT_WD_LSB = 13;
   localparam int OPT_DEPL_LSB = 11;
   localparam int OPT_FREQ_UP = 10;
   localparam int OPT_FREQ_EN = 9;
   localparam int OPT_SHORT_LSB = 7;
   localparam int OPT_LEARN = 6;
   localparam int OPT_MON_SEL = 5;
   localparam int OPT_OVC_LSB = 1;
   localparam int OPT_INHIBIT = 0;

   // watchdog period codes
   localparam logic [1:0] WD_OFF = 2'h0;
   localparam logic [1:0] WD_44 = 2'h1;
   localparam logic [1:0] WD_88 = 2'h2;

   // setting fields and resets
   localparam int CC_LSB = 6;
   localparam int CC_W = 7;
   localparam int CV_LSB = 4;
   localparam int CV_W = 11;
   localparam int IC_LSB = 7;
   localparam int IC_W = 6;
   localparam logic [15:0] CC_RST = 16'h0000;
   localparam logic [15:0] CV_RST = 16'h0000;
   localparam logic [15:0] IC_RST = 16'h1000;

   // legal setting ranges, in register codes
   localparam logic [CC_W-1:0] CC_MIN_CODE = 7'h02;
   localparam logic [CV_W-1:0] CV_MIN_CODE = 11'h040;
   localparam logic [CV_W-1:0] CV_MAX_CODE = 11'h4B0;

   // timing
   localparam int unsigned CLK_HZ = 10000000;
   localparam int unsigned T_DGL_SHORT_MS = 150;
   localparam int unsigned T_DGL_LONG_MS = 1300;
   localparam int unsigned T_WD_44_S = 44;
   localparam int unsigned T_WD_88_S = 88;
   localparam int unsigned T_WD_175_S = 175;
   localparam int unsigned DGL_SHORT_CYC = T_DGL_SHORT_MS * (CLK_HZ / 1000);
   localparam int unsigned DGL_LONG_CYC = T_DGL_LONG_MS * (CLK_HZ / 1000);
   localparam int unsigned WD_44_CYC = T_WD_44_S * CLK_HZ;
   localparam int unsigned WD_88_CYC = T_WD_88_S * CLK_HZ;
   localparam int unsigned WD_175_CYC = T_WD_175_S * CLK_HZ;

   // bus engine states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_CMD = 3'b010,
      ST_WLO = 3'b011,
      ST_WHI = 3'b100,
      ST_RSTART = 3'b101,
      ST_RLO = 3'b110,
      ST_RHI = 3'b111
   } csrb_state_e;

endpackage : csrb_pkg

// *** design/csrb_sync.sv ***
/*
 * Two-flop synchroniser bank for inputs from outside the core clock.
 * Assumes asynchronous active-low reset; outputs reset low.
 */
module csrb_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   // async in, synced out
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);

   logic [W-1:0] meta;

   for (genvar g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge i_core_clk or negedge i_reset_n) begin
         if (!i_reset_n) begin
            meta[g] <= 1'b0;
            o_sync[g] <= 1'b0;
         end else begin
            meta[g] <= i_async[g];
            o_sync[g] <= meta[g];
         end
      end
   end

endmodule : csrb_sync

// *** verification/csrb_register_bank_monitor.sv ***
/* Pin-level checks for the charger register bank.
   Assumes the bank's own clock and reset; bound below. */
module csrb_register_bank_monitor #(
   parameter logic [31:0] DGL_SHORT_CYC = 32'h14
) (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   // bus pins and enables
   input wire logic i_scl,
   input wire logic o_sda_out,
   input wire logic o_sda_oe_n,
   input wire logic i_supply_lockout,
   input wire logic i_adapter_detect_ok,
   // power path and settings
   input wire logic i_adapter_present_raw,
   input wire logic o_adapter_present_flag,
   input wire logic o_adapter_path_switch,
   input wire logic o_battery_path_switch,
   input wire logic o_charge_enable,
   input wire logic o_charge_inhibit,
   input wire logic [6:0] o_charge_current,
   input wire logic [10:0] o_charge_voltage
);
   logic [31:0] raw_run;

   default clocking @(posedge i_core_clk);
   endclocking
   default disable iff (!i_reset_n);

   // raw comparator high run length
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         raw_run <= 32'h0;
      end else begin
         raw_run <= i_adapter_present_raw ? raw_run + 32'h1 : 32'h0;
      end
   end

   sequence sq_bus_off;
      (i_supply_lockout || !i_adapter_detect_ok) [*8];
   endsequence
   sequence sq_raw_low;
      (!i_adapter_present_raw) [*5];
   endsequence

   a_sda_only_low: assert property (!o_sda_oe_n |-> !o_sda_out)
      else $error("data pin driven high");
   a_bus_off_quiet: assert property (sq_bus_off |-> o_sda_oe_n)
      else $error("bus answered while disabled");
   a_sda_scl_low: assert property ($changed(o_sda_oe_n) |-> !$past(i_scl, 2))
      else $error("data pin changed with clock high");
   a_path_exclusive: assert property (!(o_adapter_path_switch && o_battery_path_switch))
      else $error("both path switches on");
   a_charge_gate: assert property (o_charge_enable |-> $past(o_charge_current) != 7'h00 &&
      $past(o_charge_voltage) != 11'h000 && !$past(o_charge_inhibit))
      else $error("charging with zero setting or inhibit");
   a_current_floor: assert property (o_charge_current != 7'h01)
      else $error("charge current below minimum kept");
   a_voltage_range: assert property (o_charge_voltage == 11'h000 ||
      (o_charge_voltage >= csrb_pkg::CV_MIN_CODE && o_charge_voltage <= csrb_pkg::CV_MAX_CODE))
      else $error("charge voltage out of range kept");
   a_flag_rise_wait: assert property ($rose(o_adapter_present_flag) |-> raw_run >= DGL_SHORT_CYC)
      else $error("adapter flag rose before deglitch");
   a_flag_fall_fast: assert property (sq_raw_low |-> !o_adapter_present_flag)
      else $error("adapter flag stuck high");
endmodule : csrb_register_bank_monitor

bind csrb_register_bank csrb_register_bank_monitor #(.DGL_SHORT_CYC(DGL_SHORT_CYC)) csrb_register_bank_monitor_inst (.*);

// *** verification/csrb_host_model.sv ***
/* Bus host model for word writes and reads.
   Assumes a pulled-up, resolved data wire. */
module csrb_host_model (
   // bus pins
   output logic o_scl,
   output logic o_sda_drv,
   input wire logic i_sda_line
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [6:0] addr = csrb_pkg::SLAVE_ADDR;

   initial begin
      o_scl = 1'b1;
      o_sda_drv = 1'b1;
   end

   // one bit: data set in clock low, sampled mid high
   task automatic bit_io(input logic b, output logic s);
      o_scl = 1'b0;
      #100 o_sda_drv = b;
      #300 o_scl = 1'b1;
      #200 s = i_sda_line;
      #200;
   endtask : bit_io

   // start when a=1,b=0; stop when a=0,b=1
   task automatic cond(input logic a, input logic b);
      o_scl = 1'b0;
      #100 o_sda_drv = a;
      #300 o_scl = 1'b1;
      #400 o_sda_drv = b;
      #400;
   endtask : cond

   task automatic xbyte(input logic [7:0] d, input logic m_ack, output logic [7:0] q, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], s);
         q[i] = s;
      end
      bit_io(m_ack, s);
      ack = !s;
   endtask : xbyte

   task automatic write_word(input logic [7:0] cmd, input logic [15:0] d, output logic [3:0] acks);
      logic [7:0] q;
      cond(1'b1, 1'b0);
      xbyte({addr, 1'b0}, 1'b1, q, acks[3]);
      xbyte(cmd, 1'b1, q, acks[2]);
      xbyte(d[7:0], 1'b1, q, acks[1]);
      xbyte(d[15:8], 1'b1, q, acks[0]);
      cond(1'b0, 1'b1);
   endtask : write_word

   task automatic read_word(input logic [7:0] cmd, output logic [15:0] d, output logic [2:0] acks);
      logic [7:0] q;
      logic s;
      cond(1'b1, 1'b0);
      xbyte({addr, 1'b0}, 1'b1, q, acks[2]);
      xbyte(cmd, 1'b1, q, acks[1]);
      cond(1'b1, 1'b0);
      xbyte({addr, 1'b1}, 1'b1, q, acks[0]);
      xbyte(8'hFF, 1'b0, d[7:0], s);
      xbyte(8'hFF, 1'b1, d[15:8], s);
      cond(1'b0, 1'b1);
   endtask : read_word
endmodule : csrb_host_model

// *** verification/csrb_register_bank_tb.sv ***
/* Self-checking bench for the register bank.
   Assumes the host model and the bound monitor. */
module csrb_register_bank_tb;
   timeunit 1ns;
   timeprecision 1ns;
   // identity values are arbitrary
   localparam logic [15:0] MAKER_ID = 16'h3C3C;
   localparam logic [15:0] PART_ID = 16'hC3C3;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic lockout = 1'b0;
   logic det_ok = 1'b1;
   logic raw = 1'b0;
   logic depleted = 1'b0;
   logic scl, host_sda, sda_line, sda_out, sda_oe_n, flag, asw, bsw, chg_en, f_en, f_up, mon, inh;
   logic [1:0] depl, shrt, ovc;
   logic [6:0] cc;
   logic [10:0] cv;
   logic [5:0] ic;
   int miscompares = 0;
   int tests_run = 0;
   int cycles = 0;
   wire logic [15:0] pth = {13'h0000, flag, asw, bsw};
   wire logic [15:0] en_w = {15'h0000, chg_en};

   assign sda_line = host_sda & (sda_oe_n | sda_out);

   csrb_register_bank #(.DGL_SHORT_CYC(32'h14), .DGL_LONG_CYC(32'h3C), .WD_44_CYC(32'hC8), .WD_88_CYC(32'h190),
      .WD_175_CYC(32'h320), .MAKER_ID_VAL(MAKER_ID), .PART_ID_VAL(PART_ID)) csrb_register_bank_inst (
      .i_core_clk(clk), .i_reset_n(rst_n), .i_scl(scl), .i_sda(sda_line), .o_sda_out(sda_out),
      .o_sda_oe_n(sda_oe_n), .i_supply_lockout(lockout), .i_adapter_detect_ok(det_ok),
      .i_adapter_present_raw(raw), .i_battery_depleted(depleted), .o_adapter_present_flag(flag),
      .o_adapter_path_switch(asw), .o_battery_path_switch(bsw), .o_charge_enable(chg_en),
      .o_depletion_sel(depl), .o_freq_adj_en(f_en), .o_freq_adj_up(f_up), .o_high_side_short_threshold(shrt),
      .o_current_monitor_output_sel(mon), .o_input_overcurrent_limit(ovc), .o_charge_inhibit(inh),
      .o_charge_current(cc), .o_charge_voltage(cv), .o_input_current(ic));

   csrb_host_model csrb_host_model_inst (.o_scl(scl), .o_sda_drv(host_sda), .i_sda_line(sda_line));

   initial begin
      forever #50 clk = ~clk;
   end

   task automatic results;
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : results

   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         miscompares++;
         $display("[ERR] %0t run too long", $time);
         results();
      end
   end

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc

   task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic [3:0] exp_ack);
      logic [3:0] a;
      csrb_host_model_inst.write_word(c, d, a);
      check(16'(a), 16'(exp_ack));
      cyc(4);
   endtask : wr

   task automatic rd(input logic [7:0] c, input logic [15:0] exp);
      logic [15:0] d;
      logic [2:0] a;
      csrb_host_model_inst.read_word(c, d, a);
      check(16'(a), 16'h0007);
      check(d, exp);
      cyc(4);
   endtask : rd

   task automatic t_reset;
      rd(8'h12, 16'h7904);
      rd(8'h14, 16'h0000);
      rd(8'h15, 16'h0000);
      rd(8'h3F, 16'h1000);
      rd(8'hFE, MAKER_ID);
      rd(8'hFF, PART_ID);
      check({6'h00, depl, f_up, f_en, shrt, mon, ovc, inh}, 16'h0324);
   endtask : t_reset

   task automatic t_settings;
      wr(8'h14, 16'h1FC0, 4'hF);
      wr(8'h15, 16'h4B00, 4'hF);
      check(en_w, 16'h0001);
      rd(8'h14, 16'h1FC0);
      rd(8'h15, 16'h4B00);
      wr(8'h3F, 16'h1F80, 4'hF);
      rd(8'h3F, 16'h1F80);
      check({cc, ic, 3'h0}, {7'h7F, 6'h3F, 3'h0});
      wr(8'h14, 16'h0040, 4'hF);
      rd(8'h14, 16'h0000);
      check(en_w, 16'h0000);
      wr(8'h15, 16'h4B10, 4'hF);
      rd(8'h15, 16'h0000);
      wr(8'hFE, 16'h1234, 4'hF);
      rd(8'hFE, MAKER_ID);
      wr(8'h13, 16'h1234, 4'hC);
   endtask : t_settings

   task automatic t_option;
      logic [15:0] v;
      for (int i = 0; i < 4; i++) begin
         v = {1'b0, 2'(i), 2'(i), 2'(i), 2'(i), 1'b0, 1'(i), 2'h0, 2'(i), 1'b0};
         wr(8'h12, v | 16'h0018, 4'hF);
         rd(8'h12, v);
         check({7'h00, depl, f_up, f_en, shrt, mon, ovc}, {7'h00, 2'(i), 2'(i), 2'(i), 1'(i), 2'(i)});
      end
   endtask : t_option

   task automatic t_watchdog;
      wr(8'h12, 16'h2004, 4'hF);
      wr(8'h15, 16'h4B00, 4'hF);
      wr(8'h14, 16'h0100, 4'hF);
      check(en_w, 16'h0001);
      cyc(150);
      check(en_w, 16'h0001);
      cyc(100);
      check(en_w, 16'h0000);
      wr(8'h15, 16'h4B00, 4'hF);
      check(en_w, 16'h0001);
   endtask : t_watchdog

   task automatic t_learn;
      wr(8'h12, 16'h8004, 4'hF);
      raw = 1'b1;
      cyc(30);
      check(pth, 16'h0006);
      wr(8'h12, 16'h8044, 4'hF);
      check(pth, 16'h0005);
      depleted = 1'b1;
      cyc(6);
      check(pth, 16'h0006);
      depleted = 1'b0;
      rd(8'h12, 16'h8004);
      wr(8'h12, 16'h8044, 4'hF);
      wr(8'h12, 16'h8004, 4'hF);
      check(pth, 16'h0006);
      raw = 1'b0;
      cyc(6);
      check(pth, 16'h0001);
      raw = 1'b1;
      cyc(40);
      check(pth, 16'h0001);
      cyc(40);
      check(pth, 16'h0006);
   endtask : t_learn

   task automatic t_bus_off;
      lockout = 1'b1;
      wr(8'h12, 16'h0004, 4'h0);
      lockout = 1'b0;
      det_ok = 1'b0;
      wr(8'h12, 16'h0004, 4'h0);
      det_ok = 1'b1;
      csrb_host_model_inst.addr = 7'h0A;
      wr(8'h12, 16'h0004, 4'h0);
      csrb_host_model_inst.addr = csrb_pkg::SLAVE_ADDR;
      rd(8'h12, 16'h8004);
   endtask : t_bus_off

   initial begin
      cyc(8);
      rst_n = 1'b1;
      cyc(4);
      t_reset();
      t_settings();
      t_option();
      t_watchdog();
      t_learn();
      t_bus_off();
      results();
   end
endmodule : csrb_register_bank_tb
